// File: src/snvm_top.v
// serial slave front end and byte-array access of the nonvolatile memory
`timescale 1ns/1ps
`include "snvm_map.vh"
module snvm_top (
   // clock, reset, enable
   input wire clk_sys,
   input wire rst_b,
   input wire ce,
   // serial pins
   input wire cs_b,
   input wire sck,
   input wire si,
   output reg so_q,
   output reg so_oe_q,
   // control pins
   input wire wp_b,
   input wire hold_b,
   // state seen by the system
   output reg mode3_q,
   output reg busy_q
);
   localparam AW = `SNVM_ADDR_W;
   localparam DW = `SNVM_DATA_W;

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_CMD = 3'h1;
   localparam [2:0] ST_ADDR = 3'h2;
   localparam [2:0] ST_WDATA = 3'h3;
   localparam [2:0] ST_RDATA = 3'h4;
   localparam [2:0] ST_SRW = 3'h5;
   localparam [2:0] ST_SRR = 3'h6;
   localparam [2:0] ST_SKIP = 3'h7;

   // true when the byte at a lies in the protected block
   function blk_prot;
      input [AW-1:0] a;
      input [1:0] bp;
      begin
         case (bp)
            `SNVM_BP_QUARTER: blk_prot = (a[AW-1:AW-2] == 2'h3);
            `SNVM_BP_HALF: blk_prot = a[AW-1];
            `SNVM_BP_ALL: blk_prot = 1'b1;
            default: blk_prot = 1'b0;
         endcase
      end
   endfunction

   // pins pass two flops before any logic; select and pause idle high
   wire cs_s;
   wire sck_s;
   wire si_s;
   wire wp_s;
   wire hold_s;
   snvm_sync #(
      .W(5),
      .INIT(5'h1B)
   ) u_sync (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .ce(ce),
      .din({cs_b, sck, si, wp_b, hold_b}),
      .dout({cs_s, sck_s, si_s, wp_s, hold_s})
   );

   // state
   reg [2:0] st_q, st_d;
   reg [2:0] cnt_q, cnt_d;
   reg [DW-1:0] sh_q, sh_d;
   reg [DW-1:0] osh_q, osh_d;
   reg [AW-1:0] addr_q, addr_d;
   reg abyte_q, abyte_d;
   reg rd_cmd_q, rd_cmd_d;
   reg drive_q, drive_d;
   reg so_d;
   reg mode3_d;
   reg cs_q, cs_d;
   reg sck_prev_q;
   reg pen_q, pen_d;
   reg [1:0] bp_q, bp_d;
   reg wel_q, wel_d;
   // memory port
   reg mem_we;
   reg mem_re;
   reg [AW-1:0] mem_addr;
   wire [DW-1:0] mem_rdata;

   wire held = !hold_s;
   // select only follows the pin while not paused
   wire cs_fall = !held && cs_q && !cs_s;
   wire cs_rise = !held && !cs_q && cs_s;
   // clock edges only count while selected and not paused
   wire active = !held && !cs_q && !cs_s;
   wire sck_rise = active && !sck_prev_q && sck_s;
   wire sck_fall = active && sck_prev_q && !sck_s;
   wire [DW-1:0] byte_in = {sh_q[DW-2:0], si_s};
   wire [DW-1:0] status = {pen_q, 3'h0, bp_q, wel_q, 1'b0};
   wire wr_ok = wel_q && !blk_prot(addr_q, bp_q);
   wire sr_ok = wel_q && !(pen_q && !wp_s);

   always @* begin
      st_d = st_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      osh_d = osh_q;
      addr_d = addr_q;
      abyte_d = abyte_q;
      rd_cmd_d = rd_cmd_q;
      drive_d = drive_q;
      so_d = so_q;
      mode3_d = mode3_q;
      cs_d = held ? cs_q : cs_s;
      pen_d = pen_q;
      bp_d = bp_q;
      wel_d = wel_q;
      mem_we = 1'b0;
      mem_re = 1'b0;
      mem_addr = addr_q;
      if (cs_fall) begin
         // fresh command on every select fall
         st_d = ST_CMD;
         cnt_d = 3'h0;
         abyte_d = 1'b0;
         drive_d = 1'b0;
         mode3_d = sck_s;
      end else if (cs_rise) begin
         // a finished write drops the write enable latch
         if (st_q == ST_WDATA || st_q == ST_SRW || (st_q == ST_SKIP && rd_cmd_q == 1'b0 && abyte_q)) begin
            wel_d = 1'b0;
         end
         st_d = ST_IDLE;
         drive_d = 1'b0;
      end else if (sck_rise && st_q != ST_IDLE && st_q != ST_SKIP) begin
         sh_d = byte_in;
         cnt_d = cnt_q + 3'h1;
         if (cnt_q == 3'h7) begin
            case (st_q)
               ST_CMD: begin
                  // first byte is the opcode, shifted in MSB first
                  case (byte_in)
                     `SNVM_OP_WREN: begin
                        wel_d = 1'b1;
                        st_d = ST_SKIP;
                     end
                     `SNVM_OP_WRDI: begin
                        wel_d = 1'b0;
                        st_d = ST_SKIP;
                     end
                     `SNVM_OP_RDSR: st_d = ST_SRR;
                     `SNVM_OP_WRSR: st_d = ST_SRW;
                     `SNVM_OP_READ: begin
                        rd_cmd_d = 1'b1;
                        st_d = ST_ADDR;
                     end
                     `SNVM_OP_WRITE: begin
                        rd_cmd_d = 1'b0;
                        st_d = ST_ADDR;
                     end
                     default: st_d = ST_SKIP;
                  endcase
               end
               ST_ADDR: begin
                  if (!abyte_q) begin
                     // top received address bit is dropped
                     addr_d = {byte_in[AW-9:0], addr_q[7:0]};
                     abyte_d = 1'b1;
                  end else begin
                     addr_d = {addr_q[AW-1:8], byte_in};
                     if (rd_cmd_q) begin
                        mem_re = 1'b1;
                        mem_addr = {addr_q[AW-1:8], byte_in};
                        st_d = ST_RDATA;
                     end else begin
                        st_d = ST_WDATA;
                     end
                  end
               end
               ST_WDATA: begin
                  // committed on the eighth bit, nothing to poll afterwards
                  mem_we = wr_ok;
                  addr_d = addr_q + 1'b1;
               end
               ST_RDATA: begin
                  // prefetch the next byte before its first falling edge
                  mem_re = 1'b1;
                  mem_addr = addr_q + 1'b1;
                  addr_d = addr_q + 1'b1;
               end
               ST_SRW: begin
                  // mark a finished write so the select rise drops the enable latch
                  rd_cmd_d = 1'b0;
                  abyte_d = 1'b1;
                  if (sr_ok) begin
                     pen_d = byte_in[`SNVM_SR_PEN];
                     bp_d = byte_in[`SNVM_SR_BP_HI:`SNVM_SR_BP_LO];
                  end
                  st_d = ST_SKIP;
               end
               default: begin
                  // status reads repeat the same byte
                  st_d = st_q;
               end
            endcase
         end
      end else if (sck_fall && (st_q == ST_RDATA || st_q == ST_SRR)) begin
         // data leave on falling edges only
         drive_d = 1'b1;
         if (cnt_q == 3'h0) begin
            so_d = (st_q == ST_SRR) ? status[DW-1] : mem_rdata[DW-1];
            osh_d = (st_q == ST_SRR) ? {status[DW-2:0], 1'b0} : {mem_rdata[DW-2:0], 1'b0};
         end else begin
            so_d = osh_q[DW-1];
            osh_d = {osh_q[DW-2:0], 1'b0};
         end
      end
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= ST_IDLE;
         cnt_q <= 3'h0;
         sh_q <= 8'h00;
         osh_q <= 8'h00;
         addr_q <= 15'h0000;
         abyte_q <= 1'b0;
         rd_cmd_q <= 1'b0;
         drive_q <= 1'b0;
         so_q <= 1'b0;
         so_oe_q <= 1'b0;
         mode3_q <= 1'b0;
         busy_q <= 1'b0;
         cs_q <= 1'b1;
         sck_prev_q <= 1'b0;
         pen_q <= 1'b0;
         bp_q <= 2'h0;
         wel_q <= 1'b0;
      end else if (ce) begin
         // static design: no timeout, state waits for the next edge
         st_q <= st_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         osh_q <= osh_d;
         addr_q <= addr_d;
         abyte_q <= abyte_d;
         rd_cmd_q <= rd_cmd_d;
         drive_q <= drive_d;
         so_q <= so_d;
         // pause tristates, resume restores the drive
         so_oe_q <= drive_d && hold_s && !cs_d;
         mode3_q <= mode3_d;
         busy_q <= !cs_d;
         cs_q <= cs_d;
         // edge history keeps running; pause changes only with the clock low
         sck_prev_q <= sck_s;
         pen_q <= pen_d;
         bp_q <= bp_d;
         wel_q <= wel_d;
      end
   end

   snvm_mem #(
      .AW(AW),
      .DW(DW)
   ) u_mem (
      .clk_sys(clk_sys),
      .ce(ce),
      .addr(mem_addr),
      .we(mem_we),
      .wdata(byte_in),
      .re(mem_re),
      .rdata_q(mem_rdata)
   );
endmodule

// File: include/snvm_map.vh
// constants and register layout for the serial nonvolatile memory slave
// Overview of operation
// - Select high: standby, other inputs ignored, serial output tristated.
// - Select low enables internal use of the serial clock for shifting.
// - Serial input sampled only on serial clock rising edges.
// - Serial output changes on serial clock falling edges.
// - Serial clock 0 to 20 MHz, may stop anytime; state is kept.
// - Output driven only while returning read data, tristated during pause.
// - Protect pin low with protect-enable set rejects status writes.
// - Pause low suspends command, ignores serial clock and select edges.
// - Each data byte is committed on its eighth bit, no busy time.
// - Array holds 32,768 individually addressed bytes of eight bits.
// - Only modes (0, 0) and (1, 1) are supported and used.
// - Software protection of upper quarter, upper half or whole array.
// - First byte after select falls is the opcode, MSB first.
// - Unknown opcode: ignore input until next select fall, output tristated.
// - Two address bytes; only lower 15 bits used, top bit ignored.
// - Serial clock low at select fall means mode 0, high means mode 3.
`ifndef SNVM_MAP_VH
`define SNVM_MAP_VH

// array geometry
`define SNVM_ADDR_W 15
`define SNVM_DATA_W 8
`define SNVM_DEPTH 32768

// timing: system clock and the fastest serial clock
`define SNVM_CLK_NS 25
`define SNVM_SCK_MAX_MHZ 20
`define SNVM_SCK_MIN_HALF_NS (1000 / (2 * `SNVM_SCK_MAX_MHZ))
`define SNVM_SCK_MIN_HALF_CYC \
   (((`SNVM_SCK_MIN_HALF_NS + `SNVM_CLK_NS - 1) / `SNVM_CLK_NS) < 1 ? 1 : \
   ((`SNVM_SCK_MIN_HALF_NS + `SNVM_CLK_NS - 1) / `SNVM_CLK_NS))

// opcodes
`define SNVM_OP_WREN 8'h06
`define SNVM_OP_WRDI 8'h04
`define SNVM_OP_RDSR 8'h05
`define SNVM_OP_WRSR 8'h01
`define SNVM_OP_READ 8'h03
`define SNVM_OP_WRITE 8'h02

// status register fields
`define SNVM_SR_PEN 7
`define SNVM_SR_BP_HI 3
`define SNVM_SR_BP_LO 2
`define SNVM_SR_WEL 1
`define SNVM_SR_RESET 8'h00

// block protect encodings
`define SNVM_BP_NONE 2'h0
`define SNVM_BP_QUARTER 2'h1
`define SNVM_BP_HALF 2'h2
`define SNVM_BP_ALL 2'h3

`endif

// File: src/snvm_sync.v
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module snvm_sync #(
   parameter W = 1,
   parameter [W-1:0] INIT = {W{1'b0}}
) (
   // clock and reset
   input wire clk_sys,
   input wire rst_b,
   input wire ce,
   // pins and synchronised levels
   input wire [W-1:0] din,
   output wire [W-1:0] dout
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         always @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               meta_q[i] <= INIT[i];
               sync_q[i] <= INIT[i];
            end else if (ce) begin
               meta_q[i] <= din[i];
               sync_q[i] <= meta_q[i];
            end
         end
      end
   endgenerate
   assign dout = sync_q;
endmodule

// File: src/snvm_mem.v
// byte array with registered read data
`timescale 1ns/1ps
module snvm_mem #(
   parameter AW = 15,
   parameter DW = 8
) (
   // clock
   input wire clk_sys,
   input wire ce,
   // access port
   input wire [AW-1:0] addr,
   input wire we,
   input wire [DW-1:0] wdata,
   input wire re,
   output reg [DW-1:0] rdata_q
);
   reg [DW-1:0] mem [0:(1 << AW) - 1];
   always @(posedge clk_sys) begin
      if (ce) begin
         if (we) begin
            mem[addr] <= wdata;
         end
         if (re) begin
            rdata_q <= mem[addr];
         end
      end
   end
endmodule

// File: test/snvm_top_properties.sv
// pin-level assertions for the serial memory slave
`timescale 1ns/1ps
module snvm_top_props (
   // clock, reset, enable
   input wire clk_sys,
   input wire rst_b,
   input wire ce,
   // serial pins
   input wire cs_b,
   input wire sck,
   input wire si,
   input wire so_q,
   input wire so_oe_q,
   // control pins
   input wire wp_b,
   input wire hold_b,
   // observation
   input wire mode3_q,
   input wire busy_q
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   // five edges covers the two-flop sync plus the output flop
   AST_IDLE_NO_DRIVE: assert property (cs_b [*5] |-> !so_oe_q) else $error("so driven while deselected");
   AST_IDLE_NOT_BUSY: assert property ((cs_b && hold_b) [*5] |-> !busy_q) else $error("busy while idle");
   AST_SEL_BUSY: assert property ((!cs_b && hold_b) [*5] |-> busy_q) else $error("select not taken");
   AST_HOLD_NO_DRIVE: assert property (!hold_b [*5] |-> !so_oe_q) else $error("so driven in pause");
   AST_SO_ON_FALL: assert property (so_oe_q && $past(so_oe_q) && $changed(so_q) |-> !$past(sck, 2))
      else $error("so changed off a falling edge");
   AST_OE_ON_FALL: assert property ($rose(so_oe_q) |-> !$past(sck, 2)) else $error("so enabled with sck high");
   AST_MODE3_SEEN: assert property ($fell(cs_b) && sck && hold_b |-> ##6 mode3_q) else $error("mode 3 missed");
   AST_MODE0_SEEN: assert property ($fell(cs_b) && !sck && hold_b |-> ##6 !mode3_q) else $error("mode 0 missed");
   cover property ($rose(so_oe_q));
   cover property ($fell(hold_b) && busy_q);
   cover property ($fell(cs_b) && sck);
endmodule
bind snvm_top snvm_top_props i_props (.clk_sys, .rst_b, .ce, .cs_b, .sck, .si, .so_q, .so_oe_q, .wp_b, .hold_b,
   .mode3_q, .busy_q);

// File: test/snvm_mst.sv
// serial bus master model on the far side of the memory slave
`timescale 1ns/1ps
module snvm_mst (
   // clock
   input wire clk_sys,
   // pins
   output reg cs_b,
   output reg sck,
   output reg si,
   output reg hold_b,
   output reg wp_b,
   input wire so,
   input wire so_oe
);
   reg m3;
   reg oe_seen;
   initial begin
      cs_b = 1'b1;
      sck = 1'b0;
      si = 1'b0;
      hold_b = 1'b1;
      wp_b = 1'b1;
      m3 = 1'b0;
      oe_seen = 1'b0;
   end
   always @(posedge clk_sys) begin
      if (so_oe)
         oe_seen <= 1'b1;
   end
   task w(input integer n);
      begin
         repeat (n) @(posedge clk_sys);
         #2;
      end
   endtask
   // idle sck level selects mode 0 or mode 3
   task start(input md);
      begin
         m3 = md;
         sck = md;
         w(2);
         cs_b = 1'b0;
         w(4);
      end
   endtask
   // hb names the bit at which a pause is inserted, 8 for none
   task xb(input [7:0] t, input integer hb, output [7:0] r);
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            sck = 1'b0;
            si = t[i];
            w(4);
            if (i == hb) begin
               hold_b = 1'b0;
               w(4);
               sck = 1'b1;
               w(4);
               sck = 1'b0;
               w(4);
               hold_b = 1'b1;
               w(4);
            end
            sck = 1'b1;
            w(4);
            // late in the high phase, before the next fall moves so
            r[i] = so;
         end
      end
   endtask
   task stop;
      begin
         sck = m3;
         w(4);
         cs_b = 1'b1;
         si = ~si;
         w(6);
      end
   endtask
endmodule

// File: test/snvm_top_tb.sv
// self-checking bench for the serial memory slave
`timescale 1ns/1ps
`include "snvm_map.vh"
module snvm_top_tb;
   reg clk_sys = 1'b0;
   reg rst_b = 1'b0;
   reg md = 1'b0;
   reg [7:0] rx;
   reg [7:0] rb0;
   reg [7:0] rb1;
   reg [15:0] bnd;
   integer k;
   integer cyc = 0;
   integer fail_count = 0;
   integer comparisons = 0;
   wire cs_b, sck, si, so_q, so_oe_q, wp_b, hold_b, mode3_q, busy_q;
   always #12.5 clk_sys = ~clk_sys;
   snvm_mst i_mst (.clk_sys(clk_sys), .cs_b(cs_b), .sck(sck), .si(si), .hold_b(hold_b), .wp_b(wp_b),
      .so(so_q), .so_oe(so_oe_q));
   snvm_top i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .ce(1'b1), .cs_b(cs_b), .sck(sck), .si(si), .so_q(so_q),
      .so_oe_q(so_oe_q), .wp_b(wp_b), .hold_b(hold_b), .mode3_q(mode3_q), .busy_q(busy_q));
   task tally_and_finish;
      begin
         $display("compares %0d mismatches %0d", comparisons, fail_count);
         if (fail_count == 0 && comparisons > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   always @(posedge clk_sys) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         $display("wrong value at %0t: run timed out", $time);
         fail_count = fail_count + 1;
         tally_and_finish;
      end
   end
   task chk8(input [7:0] got, input [7:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            $display("wrong value at %0t: byte %h not %h", $time, got, exp);
            fail_count = fail_count + 1;
         end
      end
   endtask
   task chk1(input got, input exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            $display("wrong value at %0t: flag %b not %b", $time, got, exp);
            fail_count = fail_count + 1;
         end
      end
   endtask
   task cmd1(input [7:0] o);
      begin
         i_mst.start(md);
         i_mst.xb(o, 8, rx);
      end
   endtask
   task adr(input [7:0] o, input [15:0] a);
      begin
         cmd1(o);
         i_mst.xb(a[15:8], 8, rx);
         i_mst.xb(a[7:0], 8, rx);
      end
   endtask
   task wr2(input [15:0] a, input [7:0] d0, input [7:0] d1);
      begin
         cmd1(`SNVM_OP_WREN);
         i_mst.stop;
         adr(`SNVM_OP_WRITE, a);
         i_mst.xb(d0, 8, rx);
         i_mst.xb(d1, 8, rx);
         i_mst.stop;
      end
   endtask
   task rd2(input [15:0] a, input integer hb);
      begin
         adr(`SNVM_OP_READ, a);
         i_mst.xb(8'h00, hb, rb0);
         i_mst.xb(8'h00, 8, rb1);
         i_mst.stop;
      end
   endtask
   task wrsr(input [7:0] v);
      begin
         cmd1(`SNVM_OP_WREN);
         i_mst.stop;
         cmd1(`SNVM_OP_WRSR);
         i_mst.xb(v, 8, rx);
         i_mst.stop;
         cmd1(`SNVM_OP_RDSR);
         i_mst.xb(8'h00, 8, rx);
         i_mst.stop;
      end
   endtask
   task t_wrap;
      begin
         wr2(16'hFFFF, 8'hA5, 8'h3C);
         rd2(16'h7FFF, 8);
         chk8(rb0, 8'hA5);
         chk8(rb1, 8'h3C);
         chk1(mode3_q, 1'b0);
         $display("wrap test done");
      end
   endtask
   task t_mode3;
      begin
         md = 1'b1;
         rd2(16'h7FFF, 8);
         chk8(rb0, 8'hA5);
         chk1(mode3_q, 1'b1);
         md = 1'b0;
         $display("mode 3 test done");
      end
   endtask
   task t_refuse;
      begin
         i_mst.oe_seen = 1'b0;
         adr(8'hFF, 16'h7FFF);
         i_mst.xb(8'h00, 8, rx);
         i_mst.stop;
         chk1(i_mst.oe_seen, 1'b0);
         chk1(busy_q, 1'b0);
         $display("unknown opcode test done");
      end
   endtask
   task t_hold;
      begin
         rd2(16'h7FFF, 3);
         chk8(rb0, 8'hA5);
         chk8(rb1, 8'h3C);
         $display("pause test done");
      end
   endtask
   task t_status;
      begin
         wrsr(8'h8C);
         chk8(rx, 8'h8C);
         i_mst.wp_b = 1'b0;
         wrsr(8'h00);
         chk8(rx, 8'h8C);
         i_mst.wp_b = 1'b1;
         $display("status guard test done");
      end
   endtask
   // write across each protect boundary, first unguarded then guarded
   task t_protect;
      begin
         for (k = 1; k < 4; k = k + 1) begin
            bnd = (k == 1) ? 16'h6000 : (k == 2) ? 16'h4000 : 16'h0000;
            wrsr(8'h00);
            wr2(bnd - 16'h0001, 8'h11, 8'h11);
            wrsr({4'h0, k[1:0], 2'b00});
            wr2(bnd - 16'h0001, 8'h22, 8'h22);
            rd2(bnd - 16'h0001, 8);
            chk8(rb0, (k == 3) ? 8'h11 : 8'h22);
            chk8(rb1, 8'h11);
         end
         $display("block protect test done");
      end
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      #2;
      rst_b = 1'b1;
      i_mst.w(3);
      t_wrap;
      t_mode3;
      t_refuse;
      t_hold;
      t_status;
      t_protect;
      tally_and_finish;
   end
endmodule
